/* design/prs_seq.sv */
/*
  Rail sequencer: enables rails from control pins and power_good levels
  per the programmed table, selects memory and block-RAM levels, drives
  discharge controls and exposes registers on an Avalon-MM slave.
  Assumes pins, power_good and fault levels arrive asynchronously.
*/
// Functional notes
// - Enabling a rail releases its discharge automatically.
// - Each rail has software-selectable discharge resistance.
// - Levels, order, faults, power_good mapping from table.
// - Enables follow pin levels and power_good.
// - Pins a and e gate memory sequence.
// - Memory supply starts 2 ms after third converter.
// - Linear regulator a waits memory power_good.
// - Termination regulator waits memory power_good too.
// - Pin b: low 1.2 V, high 1.35 V.
// - Pin f: low 0.85 V, high 0.9 V.
// - Sleep select defaults on; sleep code when low.
// - Linear regulators b and c software only.
// - Separate switches: shared register drives switch c.
`timescale 1ns/1ps
`default_nettype none
module prs_seq #(
  parameter int MEM_DELAY_CYCLES = prs_pkg::MEM_DELAY_CYC,
  parameter bit SW_SEPARATE      = 1'b1
) (
  input  wire logic                           clk_in,
  input  wire logic                           rst_n_in,
  input  wire logic [4:0]                     avs_address_in,
  input  wire logic                           avs_read_in,
  input  wire logic                           avs_write_in,
  input  wire logic [31:0]                    avs_writedata_in,
  output logic      [31:0]                    avs_readdata_out,
  output logic                                avs_waitrequest_out,
  input  wire logic [prs_pkg::NUM_PINS-1:0]   ctrl_pin_in,
  input  wire logic [prs_pkg::NUM_RAILS-1:0]  power_good_in,
  input  wire logic [prs_pkg::NUM_RAILS-1:0]  rail_fault_in,
  output logic      [prs_pkg::NUM_RAILS-1:0]  rail_enable_out,
  output logic      [prs_pkg::NUM_RAILS-1:0]  discharge_on_out,
  output logic      [2*prs_pkg::NUM_RAILS-1:0] discharge_sel_out,
  output logic      [7:0]                     mem_code_out,
  output logic      [7:0]                     bram_code_out,
  output logic      [7:0]                     step_a_code_out,
  input  wire logic                           gp_out_a_in,
  output logic                                gp_out_a_out,
  output logic                                gp_out_a_oe_n_out
);
  localparam int NR = prs_pkg::NUM_RAILS;
  localparam int NP = prs_pkg::NUM_PINS;
  localparam int CW = $clog2(MEM_DELAY_CYCLES + 1);
  localparam int SW = NP + 2 * NR + 1;

  if (MEM_DELAY_CYCLES < 1) begin : g_chk
    $error("MEM_DELAY_CYCLES must be at least one");
  end

  // One counter serves the delayed rail, so the table may hold only one
  function automatic int count_delayed();
    int n;
    n = 0;
    for (int i = 0; i < NR; i++) begin
      n += int'(prs_pkg::PRS_OTP[i].dly);
    end
    return n;
  endfunction

  if (count_delayed() > 1) begin : g_chk_dly
    $error("only one delayed rail is supported");
  end

  // Rail numbers travel in four bits with the top code meaning no rail
  if (NR > 15 || NP > 7 || 2 * NR > 32) begin : g_chk_size
    $error("rail or pin count does not fit the table codes");
  end

  // Status packs the enables below the synced pins and the readback above them
  if (prs_pkg::STATUS_PIN_LSB < NR || prs_pkg::STATUS_PIN_LSB + NP > 31) begin : g_chk_status
    $error("status word layout does not fit");
  end

  typedef struct packed {
    logic [NR-1:0]   en;
    logic [NR-1:0]   sw_en;
    logic [NR-1:0]   fault;
    logic [2*NR-1:0] dis;
    logic [2:0]      shared;
    logic [7:0]      vid;
    logic [7:0]      sleep_voltage_code;
    logic            slp_sel;
    logic [CW-1:0]   dly;
    logic            ack;
    logic [31:0]     rdata;
    logic [7:0]      mem_code;
    logic [7:0]      bram_code;
    logic [7:0]      step_a_code;
    logic [NR-1:0]   dis_on;
    logic [2*NR-1:0] dis_sel;
    logic            gpo_oe_n;
  } prs_state_t;

  localparam prs_state_t ST_RST = '{
    en: '0, sw_en: '0, fault: '0, dis: prs_pkg::RST_DISCHARGE,
    shared: prs_pkg::RST_SHARED, vid: prs_pkg::RST_STEP_A_VID,
    sleep_voltage_code: prs_pkg::RST_STEP_A_SLP, slp_sel: prs_pkg::RST_SLP_SEL,
    dly: '0, ack: 1'b0, rdata: '0, mem_code: prs_pkg::CODE_MEM_LO,
    bram_code: prs_pkg::CODE_BRAM_LO, step_a_code: prs_pkg::RST_STEP_A_VID,
    dis_on: '1, dis_sel: prs_pkg::RST_DISCHARGE, gpo_oe_n: 1'b0};

  prs_state_t st_q;
  prs_state_t st_d;

  // Pins, power_good, faults and the open-drain readback all cross in
  logic [SW-1:0] sync_w;
  logic [NP-1:0] pin_s;
  logic [NR-1:0] pg_s;
  logic [NR-1:0] flt_s;
  logic          gpo_s;

  prs_sync #(
    .WIDTH (SW)
  ) u_sync (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .async_in ({gp_out_a_in, rail_fault_in, power_good_in, ctrl_pin_in}),
    .sync_out (sync_w)
  );

  assign pin_s = sync_w[NP-1:0];
  assign pg_s  = sync_w[NP+NR-1:NP];
  assign flt_s = sync_w[NP+2*NR-1:NP+NR];
  assign gpo_s = sync_w[SW-1];

  // Codes outside the pins or rails other than R_NONE never start a rail; none index anything
  function automatic logic pin_ok(input logic [2:0] sel, input logic [NP-1:0] pins);
    logic hit;
    hit = 1'b0;
    for (int p = 0; p < NP; p++) begin
      if (int'(sel) == p + 1) begin
        hit = pins[p];
      end
    end
    pin_ok = hit;
  endfunction

  function automatic logic pg_ok(input logic [3:0] src, input logic [NR-1:0] pg);
    logic good;
    good = (src == prs_pkg::R_NONE);
    for (int r = 0; r < NR; r++) begin
      if (int'(src) == r) begin
        good = pg[r];
      end
    end
    pg_ok = good;
  endfunction

  // Per-rail start condition and attributes from the programmed table
  logic [NR-1:0] rail_cond;
  logic [NR-1:0] rail_sw_only;
  logic [NR-1:0] rail_delayed;
  logic [NR-1:0] rail_masked;

  for (genvar g = 0; g < NR; g++) begin : g_rail
    assign rail_cond[g]    = pin_ok(prs_pkg::PRS_OTP[g].pin, pin_s)
                             && pg_ok(prs_pkg::PRS_OTP[g].pg_src, pg_s);
    assign rail_sw_only[g] = (prs_pkg::PRS_OTP[g].pin == prs_pkg::P_SW);
    assign rail_delayed[g] = prs_pkg::PRS_OTP[g].dly;
    assign rail_masked[g]  = prs_pkg::PRS_OTP[g].masked;
  end

  prs_pkg::prs_av_req_t req;
  assign req = '{address: avs_address_in, read: avs_read_in,
                 write: avs_write_in, writedata: avs_writedata_in};

  // One wait state on every access; the answer comes at the second edge
  assign avs_waitrequest_out = (req.read || req.write) && !st_q.ack;
  assign avs_readdata_out    = st_q.rdata;
  assign rail_enable_out     = st_q.en;
  assign discharge_on_out    = st_q.dis_on;
  assign discharge_sel_out   = st_q.dis_sel;
  assign mem_code_out        = st_q.mem_code;
  assign bram_code_out       = st_q.bram_code;
  assign step_a_code_out     = st_q.step_a_code;
  assign gp_out_a_out        = 1'b0;
  assign gp_out_a_oe_n_out   = st_q.gpo_oe_n;

  logic [3:0] shared_rail;
  assign shared_rail = SW_SEPARATE ? prs_pkg::R_SW_C : prs_pkg::R_LIN_A;

  always_comb begin
    logic            wr;
    logic            rd;
    logic            shutdown;
    logic            cond;
    logic [NR-1:0]   fault_clr;
    logic [NR-1:0]   sw_eff;
    logic [31:0]     rd_val;
    wr = 1'b0;
    rd = 1'b0;
    shutdown = 1'b0;
    cond = 1'b0;
    fault_clr = '0;
    sw_eff = '0;
    rd_val = '0;
    st_d = st_q;

    wr = req.write && st_q.ack;
    rd = req.read && !st_q.ack;
    st_d.ack = (req.read || req.write) && !st_q.ack;

    if (wr) begin
      case (req.address)
        prs_pkg::OFS_CTRL: begin
          st_d.sw_en = req.writedata[NR-1:0];
        end
        prs_pkg::OFS_FAULT: begin
          fault_clr = req.writedata[NR-1:0];
        end
        prs_pkg::OFS_DISCHARGE: begin
          st_d.dis = req.writedata[2*NR-1:0];
        end
        prs_pkg::OFS_SHARED: begin
          st_d.shared = req.writedata[2:0];
        end
        prs_pkg::OFS_STEP_A: begin
          st_d.vid     = req.writedata[7:0];
          st_d.sleep_voltage_code = req.writedata[15:8];
          st_d.slp_sel = req.writedata[prs_pkg::SLP_SEL_BIT];
        end
        default: begin
        end
      endcase
    end

    // Fault flags: a new fault wins over a clear in the same cycle
    st_d.fault = (st_q.fault & ~fault_clr) | flt_s;
    shutdown = |(st_q.fault & ~rail_masked);

    // Shared register takes over the target rail's software enable
    sw_eff = st_q.sw_en;
    sw_eff[shared_rail] = st_q.shared[2];

    st_d.dly = st_q.dly;
    for (int i = 0; i < NR; i++) begin
      cond = rail_cond[i];
      if (rail_sw_only[i]) begin
        st_d.en[i] = sw_eff[i] && !shutdown;
      end else if (rail_delayed[i]) begin
        // Only one delayed rail is served: the counter is shared
        if (!cond || shutdown) begin
          st_d.en[i] = 1'b0;
          st_d.dly   = '0;
        end else if (st_q.dly == CW'(MEM_DELAY_CYCLES)) begin
          st_d.en[i] = 1'b1;
        end else begin
          st_d.dly = st_q.dly + CW'(1);
        end
      end else begin
        st_d.en[i] = (cond || (i == int'(shared_rail) && sw_eff[i])) && !shutdown;
      end
    end

    for (int i = 0; i < NR; i++) begin
      st_d.dis_on[i] = !st_d.en[i];
      st_d.dis_sel[2*i +: 2] = (i == int'(shared_rail)) ? st_q.shared[1:0]
                                                       : st_q.dis[2*i +: 2];
    end

    st_d.mem_code  = pin_s[1] ? prs_pkg::CODE_MEM_HI : prs_pkg::CODE_MEM_LO;
    st_d.bram_code = pin_s[5] ? prs_pkg::CODE_BRAM_HI : prs_pkg::CODE_BRAM_LO;
    st_d.step_a_code = (st_q.slp_sel && !pin_s[5]) ? st_q.sleep_voltage_code : st_q.vid;
    st_d.gpo_oe_n = pg_s[prs_pkg::GPO_A_SRC];

    case (req.address)
      prs_pkg::OFS_CTRL:      rd_val[NR-1:0] = st_q.sw_en;
      prs_pkg::OFS_STATUS: begin
        rd_val[NR-1:0] = st_q.en;
        rd_val[prs_pkg::STATUS_PIN_LSB +: NP] = pin_s;
        rd_val[prs_pkg::STATUS_PIN_LSB + NP] = gpo_s;
      end
      prs_pkg::OFS_FAULT:     rd_val[NR-1:0] = st_q.fault;
      prs_pkg::OFS_DISCHARGE: rd_val[2*NR-1:0] = st_q.dis;
      prs_pkg::OFS_SHARED:    rd_val[2:0] = st_q.shared;
      prs_pkg::OFS_STEP_A: begin
        rd_val[7:0]  = st_q.vid;
        rd_val[15:8] = st_q.sleep_voltage_code;
        rd_val[prs_pkg::SLP_SEL_BIT] = st_q.slp_sel;
      end
      prs_pkg::OFS_PGOOD:     rd_val[NR-1:0] = pg_s;
      default:                rd_val = '0;
    endcase
    if (rd) begin
      st_d.rdata = rd_val;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= ST_RST;
    end else begin
      st_q <= st_d;
    end
  end
endmodule
`default_nettype wire

/* inc/prs_pkg.sv */
/*
  Shared constants and types of the rail sequencer: rail indices, the
  one-time-programmed sequence table, register offsets, reset values
  and timing. Assumes a 200 MHz system clock.
*/
package prs_pkg;

  localparam int NUM_RAILS = 13;
  localparam int NUM_PINS  = 6;

  // Rail indices
  localparam logic [3:0] R_CONV_1   = 4'h0;  // first converter rail, 3.3 V
  localparam logic [3:0] R_STEP_B   = 4'h1;  // ctrl_stepdown_b, block-RAM rail
  localparam logic [3:0] R_STEP_A   = 4'h2;  // conv_stepdown_a
  localparam logic [3:0] R_CONV_4   = 4'h3;
  localparam logic [3:0] R_STEP_C   = 4'h4;  // conv_stepdown_c, third converter
  localparam logic [3:0] R_MEM      = 4'h5;  // memory_supply_controller
  localparam logic [3:0] R_LIN_A    = 4'h6;
  localparam logic [3:0] R_LIN_B    = 4'h7;
  localparam logic [3:0] R_LIN_C    = 4'h8;
  localparam logic [3:0] R_TERM     = 4'h9;  // termination_regulator
  localparam logic [3:0] R_SW_A     = 4'ha;
  localparam logic [3:0] R_SW_B     = 4'hb;
  localparam logic [3:0] R_SW_C     = 4'hc;
  localparam logic [3:0] R_NONE     = 4'hf;

  // Enable pin select: 0 means software only, 1..6 are ctrl_pin_a..f
  localparam logic [2:0] P_SW = 3'h0;
  localparam logic [2:0] P_A  = 3'h1;
  localparam logic [2:0] P_C  = 3'h3;
  localparam logic [2:0] P_D  = 3'h4;
  localparam logic [2:0] P_E  = 3'h5;
  localparam logic [2:0] P_F  = 3'h6;

  typedef struct packed {
    logic [2:0] pin;     // enabling pin
    logic [3:0] pg_src;  // rail whose power_good must be present
    logic       dly;     // wait the memory delay after the condition
    logic       masked;  // fault on this rail does not shut down
  } prs_otp_t;

  localparam prs_otp_t PRS_OTP [NUM_RAILS] = '{
    '{P_C,  R_NONE,   1'b0, 1'b0},  // conv 1
    '{P_D,  R_STEP_A, 1'b0, 1'b0},  // step b, after external core rail
    '{P_C,  R_CONV_4, 1'b0, 1'b0},  // step a
    '{P_C,  R_STEP_C, 1'b0, 1'b0},  // conv 4
    '{P_C,  R_CONV_1, 1'b0, 1'b0},  // step c
    '{P_A,  R_STEP_C, 1'b1, 1'b0},  // memory supply
    '{P_A,  R_MEM,    1'b0, 1'b0},  // lin a
    '{P_SW, R_NONE,   1'b0, 1'b1},  // lin b
    '{P_SW, R_NONE,   1'b0, 1'b1},  // lin c
    '{P_E,  R_MEM,    1'b0, 1'b0},  // termination
    '{P_C,  R_STEP_B, 1'b0, 1'b1},  // sw a
    '{P_C,  R_STEP_B, 1'b0, 1'b1},  // sw b
    '{P_C,  R_STEP_B, 1'b0, 1'b1}   // sw c
  };
  localparam logic [3:0] GPO_A_SRC = R_STEP_A;

  // Voltage codes, 10 mV per step above 0.41 V
  localparam logic [7:0] CODE_MEM_LO  = 8'h4f;  // 1.2 V
  localparam logic [7:0] CODE_MEM_HI  = 8'h5e;  // 1.35 V
  localparam logic [7:0] CODE_BRAM_LO = 8'h2c;  // 0.85 V
  localparam logic [7:0] CODE_BRAM_HI = 8'h31;  // 0.9 V
  localparam logic [7:0] RST_STEP_A_VID = 8'h4f;
  localparam logic [7:0] RST_STEP_A_SLP = 8'h4f;
  localparam logic       RST_SLP_SEL    = 1'b1;

  // Register byte addresses
  localparam logic [4:0] OFS_CTRL      = 5'h00;
  localparam logic [4:0] OFS_STATUS    = 5'h04;
  localparam logic [4:0] OFS_FAULT     = 5'h08;
  localparam logic [4:0] OFS_DISCHARGE = 5'h0c;
  localparam logic [4:0] OFS_SHARED    = 5'h10;
  localparam logic [4:0] OFS_STEP_A    = 5'h14;
  localparam logic [4:0] OFS_PGOOD     = 5'h18;

  localparam logic [25:0] RST_DISCHARGE = 26'h0;
  localparam logic [2:0]  RST_SHARED    = 3'h0;
  localparam int          STATUS_PIN_LSB = 16;
  localparam int          SLP_SEL_BIT    = 16;

  // Timing
  localparam longint CLK_HZ       = 200_000_000;
  localparam longint MEM_DELAY_MS = 2;
  localparam int     MEM_DELAY_CYC = int'((MEM_DELAY_MS * CLK_HZ) / 1000);

  typedef struct packed {
    logic [4:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } prs_av_req_t;

endpackage

/* design/prs_sync.sv */
/*
  Two-flop synchroniser for a vector of levels.
  Assumes each bit is an independent slow level from outside the clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module prs_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule
`default_nettype wire

/* dv/prs_seq_asserts.sv */
/* Port assertions of the rail sequencer.
   Assumes a bind onto prs_seq that hands on its delay parameter. */
`timescale 1ns/1ps
`default_nettype none
module prs_seq_asserts #(
  parameter int MEM_DELAY_CYCLES = 20
) (
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic [4:0]  avs_address_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic        avs_waitrequest_out,
  input wire logic [5:0]  ctrl_pin_in,
  input wire logic [12:0] power_good_in,
  input wire logic [12:0] rail_enable_out,
  input wire logic [12:0] discharge_on_out,
  input wire logic [7:0]  mem_code_out,
  input wire logic [7:0]  bram_code_out,
  input wire logic        gp_out_a_out,
  input wire logic        gp_out_a_oe_n_out
);
  logic [3:0]  wr_age_q, wr_age_d;
  logic [15:0] cond_age_q, cond_age_d;

  // Saturating ages: edges since a control or fault-clear write, and edges the memory condition has held
  always_comb begin
    wr_age_d = (wr_age_q == 4'hf) ? wr_age_q : wr_age_q + 4'h1;
    if (avs_write_in && !avs_waitrequest_out
        && (avs_address_in == prs_pkg::OFS_CTRL || avs_address_in == prs_pkg::OFS_FAULT)) begin
      wr_age_d = 4'h0;
    end
    cond_age_d = 16'h0;
    if (ctrl_pin_in[0] && power_good_in[4]) begin
      cond_age_d = (cond_age_q == 16'hffff) ? cond_age_q : cond_age_q + 16'h1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_age_q   <= 4'hf;
      cond_age_q <= 16'h0;
    end else begin
      wr_age_q   <= wr_age_d;
      cond_age_q <= cond_age_d;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence req_open;
    (avs_read_in || avs_write_in) && avs_waitrequest_out;
  endsequence
  sequence mem_sel_hi;
    ctrl_pin_in[1] [*4];
  endsequence
  sequence bram_sel_lo;
    (!ctrl_pin_in[5]) [*4];
  endsequence

  one_wait_a: assert property (req_open |=> !avs_waitrequest_out) else $error("bus wait too long");
  dis_release_a: assert property (discharge_on_out == ~rail_enable_out)
    else $error("discharge not tied to enable");
  mem_hi_a: assert property (mem_sel_hi |-> mem_code_out == prs_pkg::CODE_MEM_HI)
    else $error("memory level wrong");
  bram_lo_a: assert property (bram_sel_lo |-> bram_code_out == prs_pkg::CODE_BRAM_LO)
    else $error("block ram level wrong");
  conv_sync_a: assert property (rail_enable_out[0] == $past(ctrl_pin_in[2], 3))
    else $error("first rail latency wrong");
  mem_delay_a: assert property ($rose(rail_enable_out[5]) |-> cond_age_q >= 16'(MEM_DELAY_CYCLES))
    else $error("memory rail early");
  lin_after_pg_a: assert property ($rose(rail_enable_out[6]) |-> $past(power_good_in[5], 3))
    else $error("linear a before memory good");
  term_after_pg_a: assert property ($rose(rail_enable_out[9]) |->
    $past(power_good_in[5], 3) && $past(ctrl_pin_in[4], 3)) else $error("termination early");
  sw_only_a: assert property (|(rail_enable_out[8:7] & ~$past(rail_enable_out[8:7])) |->
    wr_age_q < 4'h4) else $error("software rail rose without write");
  gpo_map_a: assert property (gp_out_a_oe_n_out == $past(power_good_in[2], 3) && !gp_out_a_out)
    else $error("gpo mapping wrong");
endmodule

bind prs_seq prs_seq_asserts #(.MEM_DELAY_CYCLES(MEM_DELAY_CYCLES)) u_prs_seq_asserts (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_waitrequest_out(avs_waitrequest_out), .ctrl_pin_in(ctrl_pin_in),
  .power_good_in(power_good_in), .rail_enable_out(rail_enable_out), .discharge_on_out(discharge_on_out),
  .mem_code_out(mem_code_out), .bram_code_out(bram_code_out), .gp_out_a_out(gp_out_a_out),
  .gp_out_a_oe_n_out(gp_out_a_oe_n_out));
`default_nettype wire

/* dv/prs_board_model.sv */
/* Board model: rails report good some cycles after enable, the open-drain
   gpo has a pull-up, and its level returns to control pin d.
   Assumes the same clock and reset as the sequencer. */
`timescale 1ns/1ps
`default_nettype none
module prs_board_model #(
  parameter int PG_DLY = 4
) (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [12:0] rail_enable_in,
  input  wire logic        gpo_drive_in,
  input  wire logic        gpo_oe_n_in,
  output logic      [12:0] power_good_out,
  output logic             gpo_wire_out,
  output logic             ctrl_pin_d_out
);
  int cnt [13];

  // Pull-up wins whenever the device lets go of the pin
  assign gpo_wire_out   = gpo_oe_n_in ? 1'b1 : gpo_drive_in;
  assign ctrl_pin_d_out = gpo_wire_out;

  // Good drops at once with the enable, so a late rail is never reported good
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < 13; i++) begin
        cnt[i]            <= 0;
        power_good_out[i] <= 1'b0;
      end
    end else begin
      for (int i = 0; i < 13; i++) begin
        if (!rail_enable_in[i]) begin
          cnt[i]            <= 0;
          power_good_out[i] <= 1'b0;
        end else if (cnt[i] < PG_DLY) begin
          cnt[i] <= cnt[i] + 1;
        end else begin
          power_good_out[i] <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* dv/tb_top.sv */
/* Self-checking bench of the rail sequencer with the board model.
   Assumes a short memory delay parameter for simulation. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int MEMD = 20;
  localparam int PGD  = 4;
  logic        clk_in, rst_n_in, avs_read, avs_write;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, rdata, q;
  logic        wait_req, gpo, oe_n, gpo_wire, pin_d;
  logic [5:0]  drv, pins;
  logic [12:0] en, dis_on, pg, flt;
  logic [25:0] dis_sel;
  logic [7:0]  mem_code, bram_code, step_code;
  int          n_fail, compares, n;
  assign pins = {drv[5:4], pin_d, drv[2:0]};

  prs_seq #(.MEM_DELAY_CYCLES(MEMD)) u_prs_seq (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .avs_address_in(avs_address), .avs_read_in(avs_read),
    .avs_write_in(avs_write), .avs_writedata_in(avs_writedata), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wait_req), .ctrl_pin_in(pins), .power_good_in(pg), .rail_fault_in(flt),
    .rail_enable_out(en), .discharge_on_out(dis_on), .discharge_sel_out(dis_sel), .mem_code_out(mem_code),
    .bram_code_out(bram_code), .step_a_code_out(step_code), .gp_out_a_in(gpo_wire), .gp_out_a_out(gpo),
    .gp_out_a_oe_n_out(oe_n));
  prs_board_model #(.PG_DLY(PGD)) u_prs_board_model (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .rail_enable_in(en), .gpo_drive_in(gpo), .gpo_oe_n_in(oe_n), .power_good_out(pg),
    .gpo_wire_out(gpo_wire), .ctrl_pin_d_out(pin_d));

  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Master holds the request until it samples waitrequest low at a rising edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] rd);
    int k;
    k = 0;
    @(posedge clk_in);
    avs_address <= a;
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= d;
    do begin
      @(posedge clk_in);
      k++;
    end while (wait_req !== 1'b0 && k < 20);
    rd = rdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (k >= 20) begin
      n_fail++;
      report_and_stop;
    end
  endtask

  task automatic settle(input int k);
    repeat (k) @(posedge clk_in);
    @(negedge clk_in);
  endtask

  // Counts rising edges after the driving edge until the rail is on
  task automatic wait_en(input int i, output int k);
    k = 0;
    @(negedge clk_in);
    while (en[i] !== 1'b1 && k < 600) begin
      @(negedge clk_in);
      k++;
    end
    if (k >= 600) begin
      n_fail++;
      report_and_stop;
    end
  endtask

  task automatic t_reset;
    settle(0);
    chk("enables", 32'h0, {19'h0, en});
    chk("discharge", 32'h1fff, {19'h0, dis_on});
    chk("codes", 32'h4f2c4f, {8'h0, mem_code, bram_code, step_code});
    bus(1'b0, prs_pkg::OFS_STEP_A, 32'h0, q);
    chk("step a reg", 32'h00014f4f, q);
    bus(1'b1, 5'h1c, 32'hffffffff, q);
    bus(1'b0, 5'h1c, 32'h0, q);
    chk("unmapped", 32'h0, q);
    $display("test reset done");
  endtask

  task automatic t_levels;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_in);
      drv[1] <= i[0];
      drv[5] <= i[1];
      settle(3);
      chk("mem code", {24'h0, i[0] ? prs_pkg::CODE_MEM_HI : prs_pkg::CODE_MEM_LO}, {24'h0, mem_code});
      chk("bram code", {24'h0, i[1] ? prs_pkg::CODE_BRAM_HI : prs_pkg::CODE_BRAM_LO}, {24'h0, bram_code});
    end
    $display("test levels done");
  endtask

  task automatic t_sleep;
    bus(1'b1, prs_pkg::OFS_STEP_A, 32'h00016055, q);
    drv[5] <= 1'b0;
    settle(3);
    chk("sleep code", 32'h60, {24'h0, step_code});
    @(posedge clk_in);
    drv[5] <= 1'b1;
    settle(3);
    chk("run code", 32'h55, {24'h0, step_code});
    $display("test sleep done");
  endtask

  task automatic t_power_up;
    @(posedge clk_in);
    drv[2] <= 1'b1;
    wait_en(0, n);
    chk("first rail latency", 32'd3, n);
    settle(300);
    chk("enables gated", 32'h1c1f, {19'h0, en});
    chk("discharge", 32'h03e0, {19'h0, dis_on});
    bus(1'b0, prs_pkg::OFS_STATUS, 32'h0, q);
    chk("status", 32'h006e1c1f, q);
    bus(1'b0, prs_pkg::OFS_PGOOD, 32'h0, q);
    chk("power good", 32'h00001c1f, q);
    @(posedge clk_in);
    drv[0] <= 1'b1;
    wait_en(5, n);
    chk("memory delay", 32'h1, {31'h0, n >= MEMD + 3 && n <= MEMD + 5});
    chk("lin a early", 32'h0, {31'h0, en[6]});
    wait_en(6, n);
    chk("lin a after good", 32'h1, {31'h0, n > PGD});
    chk("termination gated", 32'h0, {31'h0, en[9]});
    @(posedge clk_in);
    drv[4] <= 1'b1;
    wait_en(9, n);
    chk("termination latency", 32'd3, n);
    $display("test power up done");
  endtask

  task automatic t_software;
    bus(1'b1, prs_pkg::OFS_CTRL, 32'h180, q);
    @(posedge clk_in);
    drv <= 6'h0;
    settle(16);
    chk("software rails", 32'h0180, {19'h0, en});
    bus(1'b1, prs_pkg::OFS_SHARED, 32'h4, q);
    settle(4);
    chk("shared switch", 32'h1180, {19'h0, en});
    bus(1'b1, prs_pkg::OFS_CTRL, 32'h0, q);
    bus(1'b1, prs_pkg::OFS_SHARED, 32'h0, q);
    settle(4);
    chk("all off", 32'h0, {19'h0, en});
    bus(1'b1, prs_pkg::OFS_DISCHARGE, 32'h02c6a51b, q);
    bus(1'b0, prs_pkg::OFS_DISCHARGE, 32'h0, q);
    chk("discharge reg", 32'h02c6a51b, q);
    chk("discharge sel", 32'h00c6a51b, {6'h0, dis_sel});
    bus(1'b1, prs_pkg::OFS_SHARED, 32'h3, q);
    settle(1);
    chk("shared discharge", 32'h03c6a51b, {6'h0, dis_sel});
    $display("test software done");
  endtask

  // A masked fault only flags; an unmasked one drops every rail until cleared
  task automatic t_fault;
    bus(1'b1, prs_pkg::OFS_CTRL, 32'h180, q);
    flt <= 13'h080;
    settle(6);
    chk("masked fault", 32'h0180, {19'h0, en});
    @(posedge clk_in);
    flt <= 13'h001;
    settle(6);
    chk("fault shutdown", 32'h0, {19'h0, en});
    chk("fault discharge", 32'h1fff, {19'h0, dis_on});
    @(posedge clk_in);
    flt <= 13'h000;
    settle(3);
    bus(1'b0, prs_pkg::OFS_FAULT, 32'h0, q);
    chk("fault flags", 32'h0081, q);
    bus(1'b1, prs_pkg::OFS_FAULT, 32'h1fff, q);
    settle(4);
    chk("fault cleared", 32'h0180, {19'h0, en});
    $display("test fault done");
  endtask

  initial begin
    rst_n_in = 1'b0;
    drv = 6'h0;
    flt = 13'h0;
    avs_address = 5'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    n_fail = 0;
    compares = 0;
    repeat (20) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_reset;
    t_levels;
    t_sleep;
    t_power_up;
    t_software;
    t_fault;
    report_and_stop;
  end
endmodule
`default_nettype wire
